// ---- tpg_pkg.sv ----
// Purpose: Shared constants and types for the down-converter test-pattern source.
// Assumes: 8-bit register port, 16-bit sample words.
// Notes: Offsets are register indices on the plain register port.
package tpg_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_USER_ONE_LO = 8'h33;
    localparam logic [7:0] ADDR_USER_ONE_HI = 8'h34;
    localparam logic [7:0] ADDR_USER_TWO_LO = 8'h35;
    localparam logic [7:0] ADDR_USER_TWO_HI = 8'h36;
    localparam logic [7:0] ADDR_COMMON_SEL = 8'h37;
    localparam logic [7:0] ADDR_UNIT2_SEL = 8'h38;
    localparam logic [7:0] ADDR_SHARED_CHOICE = 8'h39;
    localparam logic [7:0] ADDR_RESTART_CTRL = 8'h3A;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] SEL_MASK = 8'h0F;
    localparam logic [7:0] BIT0_MASK = 8'h01;
    localparam logic [7:0] BIT01_MASK = 8'h03;

    // ==========================================================
    // Field positions
    localparam int INPHASE_LSB = 0;
    localparam int QUAD_LSB = 4;
    localparam int PERMIT_BIT = 0;
    localparam int RESTART_BIT = 1;

    // ==========================================================
    // Pattern codes and words
    localparam logic [3:0] PAT_NORMAL = 4'h0;
    localparam logic [3:0] PAT_ZEROS = 4'h1;
    localparam logic [3:0] PAT_ONES = 4'h2;
    localparam logic [3:0] PAT_TOGGLE = 4'h3;
    localparam logic [3:0] PAT_RAMP = 4'h4;
    localparam logic [3:0] PAT_SINGLE = 4'h6;
    localparam logic [3:0] PAT_DOUBLE = 4'h7;
    localparam logic [3:0] PAT_DESKEW = 4'h8;
    localparam logic [3:0] PAT_SYNC = 4'h9;
    localparam logic [15:0] WORD_ZEROS = 16'h0000;
    localparam logic [15:0] WORD_ONES = 16'hFFFF;
    localparam logic [15:0] WORD_TOGGLE_A = 16'h2AAA;
    localparam logic [15:0] WORD_TOGGLE_B = 16'h1555;
    localparam logic [15:0] WORD_DESKEW = 16'hAAAA;
    localparam logic [15:0] WORD_SYNC = 16'hFFFF;
    localparam logic [15:0] RAMP_STEP = 16'h0001;

    // ==========================================================
    // Sample pair carried through the buffer
    typedef struct packed {
        logic [15:0] quad;
        logic [15:0] inphase;
    } sample_pair_t;

    localparam int PAIR_W = 32;
    localparam int FIFO_DEPTH = 8;

endpackage

// ---- tpg_fifo.sv ----
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Depth is a power of two.
// Notes: Full and empty derive from an occupancy count.
`timescale 1ns/1ps
module tpg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_o = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem[rd_ptr_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            if (push && !pop) begin
                count_r <= count_r + (AW+1)'(1);
            end else if (pop && !push) begin
                count_r <= count_r - (AW+1)'(1);
            end
        end
    end
endmodule // tpg_fifo

// ---- ddc_test_pattern_generator.sv ----
// Purpose: Replaces second down-converter I/Q sample streams with test patterns.
// Assumes: Converter samples arrive on clk_i with a valid/ready handshake.
// Notes: Patterns advance once per pair accepted from the converter.
`timescale 1ns/1ps
// How it works
// - Bits 7-4 select quadrature stream pattern.
// - Bits 3-0 select in-phase stream pattern.
// - Code 0001 drives all-zero words.
// - Code 0010 drives all-one words.
// - Code 0011 alternates toggle words 2AAAh and 1555h.
// - Code 0100 ramps up one per word.
// - Code 0110 repeats user word one.
// - Code 0111 alternates user words one, two.
// - Code 1000 drives deskew word AAAAh.
// - Code 1001 drives sync word FFFFh.
// - Shared bit 0 uses common selector.
// - Shared bit 1 uses per-stream selectors.
// - Restart acts only while permit is set.
// - Two user words in four byte registers.
// - Common selector shares codes, 0000 normal.
module ddc_test_pattern_generator (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    // Converter samples in
    input wire logic conv_valid_i,
    output logic conv_ready_o,
    input wire tpg_pkg::sample_pair_t conv_data_i,
    // Samples out toward serial link
    output logic out_valid_o,
    input wire logic out_ready_i,
    output tpg_pkg::sample_pair_t out_data_o
);
    // ==========================================================
    // Registers
    logic [15:0] user_word_one_r;
    logic [15:0] user_word_two_r;
    logic [3:0] common_select_r;
    logic [3:0] unit2_quadrature_select_r;
    logic [3:0] unit2_inphase_select_r;
    logic shared_choice_r;
    logic generator_restart_permit_r;
    logic generator_restart_pulse_r;
    logic [7:0] reg_rdata_r;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            user_word_one_r <= {tpg_pkg::REG_RESET, tpg_pkg::REG_RESET};
            user_word_two_r <= {tpg_pkg::REG_RESET, tpg_pkg::REG_RESET};
            common_select_r <= tpg_pkg::PAT_NORMAL;
            unit2_quadrature_select_r <= tpg_pkg::PAT_NORMAL;
            unit2_inphase_select_r <= tpg_pkg::PAT_NORMAL;
            shared_choice_r <= 1'b0;
            generator_restart_permit_r <= 1'b0;
            generator_restart_pulse_r <= 1'b0;
        end else if (reg_write_i) begin
            unique case (reg_addr_i)
                tpg_pkg::ADDR_USER_ONE_LO: user_word_one_r[7:0] <= reg_wdata_i;
                tpg_pkg::ADDR_USER_ONE_HI: user_word_one_r[15:8] <= reg_wdata_i;
                tpg_pkg::ADDR_USER_TWO_LO: user_word_two_r[7:0] <= reg_wdata_i;
                tpg_pkg::ADDR_USER_TWO_HI: user_word_two_r[15:8] <= reg_wdata_i;
                tpg_pkg::ADDR_COMMON_SEL: begin
                    common_select_r <= reg_wdata_i[3:0];
                end
                tpg_pkg::ADDR_UNIT2_SEL: begin
                    unit2_quadrature_select_r <= reg_wdata_i[tpg_pkg::QUAD_LSB +: 4];
                    unit2_inphase_select_r <= reg_wdata_i[tpg_pkg::INPHASE_LSB +: 4];
                end
                tpg_pkg::ADDR_SHARED_CHOICE: begin
                    shared_choice_r <= reg_wdata_i[0];
                end
                tpg_pkg::ADDR_RESTART_CTRL: begin
                    generator_restart_permit_r <= reg_wdata_i[tpg_pkg::PERMIT_BIT];
                    generator_restart_pulse_r <= reg_wdata_i[tpg_pkg::RESTART_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data stand one cycle after the read strobe; unmapped reads return zero.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_r <= tpg_pkg::REG_RESET;
        end else if (reg_read_i) begin
            unique case (reg_addr_i)
                tpg_pkg::ADDR_USER_ONE_LO: reg_rdata_r <= user_word_one_r[7:0];
                tpg_pkg::ADDR_USER_ONE_HI: reg_rdata_r <= user_word_one_r[15:8];
                tpg_pkg::ADDR_USER_TWO_LO: reg_rdata_r <= user_word_two_r[7:0];
                tpg_pkg::ADDR_USER_TWO_HI: reg_rdata_r <= user_word_two_r[15:8];
                tpg_pkg::ADDR_COMMON_SEL: reg_rdata_r <= {4'h0, common_select_r};
                tpg_pkg::ADDR_UNIT2_SEL: begin
                    reg_rdata_r <= {unit2_quadrature_select_r, unit2_inphase_select_r};
                end
                tpg_pkg::ADDR_SHARED_CHOICE: reg_rdata_r <= {7'h00, shared_choice_r};
                tpg_pkg::ADDR_RESTART_CTRL: begin
                    reg_rdata_r <= {6'h00, generator_restart_pulse_r, generator_restart_permit_r};
                end
                default: reg_rdata_r <= tpg_pkg::REG_RESET;
            endcase
        end else begin
            reg_rdata_r <= tpg_pkg::REG_RESET;
        end
    end

    assign reg_rdata_o = reg_rdata_r;

    // ==========================================================
    // Pattern state
    logic restart_now;
    logic advance;
    logic phase_r;
    logic [15:0] ramp_r;
    logic conv_ready_r;

    assign restart_now = generator_restart_permit_r && generator_restart_pulse_r;
    // A pair is taken only while the ready shown to the converter is high.
    assign advance = conv_valid_i && conv_ready_r;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_r <= 1'b0;
            ramp_r <= tpg_pkg::WORD_ZEROS;
        end else if (restart_now) begin
            phase_r <= 1'b0;
            ramp_r <= tpg_pkg::WORD_ZEROS;
        end else if (advance) begin
            phase_r <= ~phase_r;
            ramp_r <= ramp_r + tpg_pkg::RAMP_STEP;
        end
    end

    // ==========================================================
    // Pattern selection
    function automatic logic [15:0] pick(
        input logic [3:0] code,
        input logic [15:0] conv,
        input logic phase,
        input logic [15:0] ramp,
        input logic [15:0] one,
        input logic [15:0] two
    );
        logic [15:0] word;
        word = conv;
        unique case (code)
            tpg_pkg::PAT_ZEROS: word = tpg_pkg::WORD_ZEROS;
            tpg_pkg::PAT_ONES: word = tpg_pkg::WORD_ONES;
            tpg_pkg::PAT_TOGGLE: begin
                word = phase ? tpg_pkg::WORD_TOGGLE_B : tpg_pkg::WORD_TOGGLE_A;
            end
            tpg_pkg::PAT_RAMP: word = ramp;
            tpg_pkg::PAT_SINGLE: word = one;
            tpg_pkg::PAT_DOUBLE: word = phase ? two : one;
            tpg_pkg::PAT_DESKEW: word = tpg_pkg::WORD_DESKEW;
            tpg_pkg::PAT_SYNC: word = tpg_pkg::WORD_SYNC;
            default: word = conv;
        endcase
        return word;
    endfunction

    logic [3:0] quad_code;
    logic [3:0] inph_code;
    tpg_pkg::sample_pair_t gen_pair;

    always_comb begin
        if (shared_choice_r) begin
            quad_code = unit2_quadrature_select_r;
            inph_code = unit2_inphase_select_r;
        end else begin
            quad_code = common_select_r;
            inph_code = common_select_r;
        end
        gen_pair.quad = pick(quad_code, conv_data_i.quad, phase_r, ramp_r,
            user_word_one_r, user_word_two_r);
        gen_pair.inphase = pick(inph_code, conv_data_i.inphase, phase_r, ramp_r,
            user_word_one_r, user_word_two_r);
    end

    // ==========================================================
    // Output buffer and registered output stage
    logic fifo_out_valid;
    logic fifo_out_ready;
    tpg_pkg::sample_pair_t fifo_out_data;
    logic out_valid_r;
    tpg_pkg::sample_pair_t out_data_r;
    localparam int OCC_W = $clog2(tpg_pkg::FIFO_DEPTH) + 1;
    logic pop_word;
    logic [OCC_W-1:0] occ_r;
    logic [OCC_W-1:0] occ_nxt;

    tpg_fifo #(
        .WIDTH(tpg_pkg::PAIR_W),
        .DEPTH(tpg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(advance),
        .in_ready_o(),
        .in_data_i(gen_pair),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    assign fifo_out_ready = !out_valid_r || out_ready_i;
    assign pop_word = fifo_out_valid && fifo_out_ready;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_valid_r <= 1'b0;
        end else if (fifo_out_ready) begin
            out_valid_r <= fifo_out_valid;
        end
    end

    // The output word is loaded only with a real pair, so it never shows stale memory.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_data_r <= '0;
        end else if (pop_word) begin
            out_data_r <= fifo_out_data;
        end
    end

    // Occupancy mirrors the FIFO so that ready comes straight from a flip-flop.
    always_comb begin
        occ_nxt = occ_r;
        if (advance && !pop_word) begin
            occ_nxt = occ_r + OCC_W'(1);
        end else if (pop_word && !advance) begin
            occ_nxt = occ_r - OCC_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            occ_r <= '0;
            conv_ready_r <= 1'b0;
        end else begin
            occ_r <= occ_nxt;
            conv_ready_r <= (occ_nxt != OCC_W'(tpg_pkg::FIFO_DEPTH));
        end
    end

    assign conv_ready_o = conv_ready_r;
    assign out_valid_o = out_valid_r;
    assign out_data_o = out_data_r;

endmodule // ddc_test_pattern_generator

// ---- ddc_test_pattern_generator_assertions.sv ----
// Purpose: Port-level checks for the test-pattern source.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module tpg_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    // Sample streams
    input wire logic conv_valid_i,
    input wire logic conv_ready_o,
    input wire tpg_pkg::sample_pair_t conv_data_i,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire tpg_pkg::sample_pair_t out_data_o
);
    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_wr_sel;
        reg_write_i && reg_addr_i == 8'h38;
    endsequence
    sequence s_rd_sel;
        reg_read_i && reg_addr_i == 8'h38;
    endsequence
    a_rdata_idle_zero: assert property (
        !$past(reg_read_i) |-> reg_rdata_o == 8'h00) else $error("read data not zero");
    a_unmapped_read: assert property (
        $past(reg_read_i) && ($past(reg_addr_i) < 8'h33 || $past(reg_addr_i) > 8'h3A)
        |-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_common_sel_rsvd: assert property (
        $past(reg_read_i) && $past(reg_addr_i) == 8'h37 |-> reg_rdata_o[7:4] == 4'h0)
        else $error("common select upper bits set");
    a_choice_rsvd: assert property (
        $past(reg_read_i) && $past(reg_addr_i) == 8'h39 |-> reg_rdata_o[7:1] == 7'h00)
        else $error("choice upper bits set");
    a_restart_rsvd: assert property (
        $past(reg_read_i) && $past(reg_addr_i) == 8'h3A |-> reg_rdata_o[7:2] == 6'h00)
        else $error("restart upper bits set");
    a_sel_readback: assert property (
        s_wr_sel ##1 s_rd_sel |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("selector readback wrong");
    a_out_hold_word: assert property (
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("output word dropped");
    a_accept_emerges: assert property (
        conv_valid_i && conv_ready_o |-> ##[1:3] out_valid_o)
        else $error("accepted pair never shown");
endmodule // tpg_checker
bind ddc_test_pattern_generator tpg_checker u_chk (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
    .reg_write_i, .reg_read_i, .reg_rdata_o, .conv_valid_i, .conv_ready_o, .conv_data_i,
    .out_valid_o, .out_ready_i, .out_data_o);

// ---- tpg_sink_model.sv ----
// Purpose: Receiver standing where the serial link takes the samples.
// Assumes: Pace 0 prompt, 1 slow, 2 stalled.
// Notes: Accepted pairs collect in a queue.
`timescale 1ns/1ps
module tpg_sink_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Pace control
    input wire logic [1:0] mode_i,
    // Sample stream
    input wire logic valid_i,
    input wire tpg_pkg::sample_pair_t data_i,
    output logic ready_o
);
    tpg_pkg::sample_pair_t got[$];
    logic [1:0] pace_r;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i)
            pace_r <= 2'h0;
        else
            pace_r <= pace_r + 2'h1;
    end
    assign ready_o = (mode_i == 2'h0) || (mode_i == 2'h1 && pace_r[1]);
    always @(posedge clk_i) begin
        if (!reset_i && valid_i && ready_o)
            got.push_back(data_i);
    end
endmodule // tpg_sink_model

// ---- ddc_test_pattern_generator_test.sv ----
// Purpose: Self-checking bench for the test-pattern source.
// Assumes: Expected words track pairs accepted since reset or restart.
// Notes: Sink model paces the output side.
`timescale 1ns/1ps
module ddc_test_pattern_generator_test;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic conv_valid_i = 1'b0;
    logic conv_ready_o;
    tpg_pkg::sample_pair_t conv_data_i = 32'h0000_0000;
    logic out_valid_o;
    logic out_ready_i;
    tpg_pkg::sample_pair_t out_data_o;
    logic [1:0] sink_mode = 2'h0;
    int mismatches = 0;
    int n_checks = 0;
    int acc = 0;
    logic own = 1'b0;
    logic [3:0] com = 4'h0;
    logic [3:0] qs = 4'h0;
    logic [3:0] ins = 4'h0;
    logic [15:0] w1 = 16'h0000;
    logic [15:0] w2 = 16'h0000;
    tpg_pkg::sample_pair_t exp_q[$];
    always #2.5 clk_i = ~clk_i;
    ddc_test_pattern_generator u_dut (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
        .reg_read_i, .reg_rdata_o, .conv_valid_i, .conv_ready_o, .conv_data_i, .out_valid_o,
        .out_ready_i, .out_data_o);
    tpg_sink_model u_sink (.clk_i, .reset_i, .mode_i(sink_mode), .valid_i(out_valid_o),
        .data_i(out_data_o), .ready_o(out_ready_i));
    // ==========================================================
    // Shared tasks
    task check(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task conclude;
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [15:0] pat(input logic [3:0] c, input logic [15:0] d);
        case (c)
            tpg_pkg::PAT_ZEROS: return tpg_pkg::WORD_ZEROS;
            tpg_pkg::PAT_ONES: return tpg_pkg::WORD_ONES;
            tpg_pkg::PAT_TOGGLE: return acc[0] ? tpg_pkg::WORD_TOGGLE_B : tpg_pkg::WORD_TOGGLE_A;
            tpg_pkg::PAT_RAMP: return acc[15:0];
            tpg_pkg::PAT_SINGLE: return w1;
            tpg_pkg::PAT_DOUBLE: return acc[0] ? w2 : w1;
            tpg_pkg::PAT_DESKEW: return tpg_pkg::WORD_DESKEW;
            tpg_pkg::PAT_SYNC: return tpg_pkg::WORD_SYNC;
            default: return d;
        endcase
    endfunction
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        @(negedge clk_i);
        check("rdata", {24'h0, e}, {24'h0, reg_rdata_o});
    endtask
    task note;
        exp_q.push_back({pat(own ? qs : com, conv_data_i.quad),
            pat(own ? ins : com, conv_data_i.inphase)});
        acc++;
    endtask
    task push(input int n);
        int w;
        for (int k = 0; k < n; k++) begin
            conv_valid_i <= 1'b1;
            conv_data_i <= {16'h4000 + 16'(k), 16'h0100 + 16'(acc)};
            w = 0;
            @(posedge clk_i);
            while (conv_ready_o !== 1'b1 && w < 50) begin
                w++;
                @(posedge clk_i);
            end
            note();
        end
        conv_valid_i <= 1'b0;
    endtask
    task drain;
        int w;
        tpg_pkg::sample_pair_t g;
        w = 0;
        while (u_sink.got.size() < exp_q.size() && w < 400) begin
            w++;
            @(posedge clk_i);
        end
        check("count", 32'(exp_q.size()), 32'(u_sink.got.size()));
        while (exp_q.size() > 0 && u_sink.got.size() > 0) begin
            g = u_sink.got.pop_front();
            check("pair", exp_q.pop_front(), g);
        end
        exp_q.delete();
        u_sink.got.delete();
    endtask
    // ==========================================================
    // Scenarios
    task t_regs;
        for (int r = 8'h33; r <= 8'h3A; r++)
            rd_chk(8'(r), 8'h00);
        rd_chk(8'h40, 8'h00);
        wr(8'h33, 8'h5A);
        wr(8'h34, 8'hA5);
        wr(8'h35, 8'hC3);
        wr(8'h36, 8'h3C);
        w1 = 16'hA55A;
        w2 = 16'h3CC3;
        rd_chk(8'h34, 8'hA5);
        rd_chk(8'h35, 8'hC3);
        wr(8'h37, 8'h0F);
        rd_chk(8'h37, 8'h0F);
        wr(8'h39, 8'h01);
        rd_chk(8'h39, 8'h01);
        wr(8'h3A, 8'h01);
        wr(8'h3A, 8'h03);
        rd_chk(8'h3A, 8'h03);
        wr(8'h3A, 8'h00);
        wr(8'h37, 8'h00);
        @(posedge clk_i);
        reg_addr_i <= 8'h38;
        reg_wdata_i <= 8'h96;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        @(negedge clk_i);
        check("sel", 32'h96, {24'h0, reg_rdata_o});
    endtask
    task t_codes;
        wr(8'h39, 8'h01);
        own = 1'b1;
        for (int c = 0; c < 11; c++) begin
            qs = 4'(c);
            ins = 4'(10 - c);
            wr(8'h38, {qs, ins});
            push(3);
            drain();
        end
    endtask
    task t_common;
        wr(8'h39, 8'h00);
        own = 1'b0;
        for (int c = 0; c < 10; c += 3) begin
            com = 4'(c);
            wr(8'h37, {4'h0, com});
            push(2);
            drain();
        end
    endtask
    task t_restart;
        com = 4'h4;
        wr(8'h37, 8'h04);
        wr(8'h3A, 8'h02);
        wr(8'h3A, 8'h00);
        push(2);
        drain();
        wr(8'h3A, 8'h01);
        wr(8'h3A, 8'h03);
        wr(8'h3A, 8'h01);
        acc = 0;
        push(3);
        drain();
    endtask
    task t_fill;
        int n;
        sink_mode <= 2'h2;
        conv_valid_i <= 1'b1;
        for (n = 0; n < 20; n++) begin
            conv_data_i <= {16'h7000 + 16'(n), 16'h0200 + 16'(n)};
            @(posedge clk_i);
            if (conv_ready_o !== 1'b1)
                break;
            note();
        end
        conv_valid_i <= 1'b0;
        check("refused", 32'h1, {31'h0, n < 20});
        sink_mode <= 2'h1;
        drain();
    endtask
    // ==========================================================
    // Sequence and watchdog
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_codes();
        t_common();
        t_restart();
        t_fill();
        conclude();
    end
    initial begin
        #50000;
        mismatches++;
        conclude();
    end
endmodule // ddc_test_pattern_generator_test
